// file: pkg/slow_osc_pkg.sv
// Package with register map, field layout and types of the slow oscillator control block.
package slow_osc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_EXT_CTRL = 8'h14;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h48;
    localparam logic [31:0] INT_CTRL_RESET = 32'h003F0080;
    localparam logic [31:0] INT_CTRL_WMASK = 32'h007F17C6;
    localparam logic [15:0] EXT_CTRL_RESET = 16'h0080;
    localparam logic [15:0] EXT_CTRL_WMASK = 16'h17EE;
    localparam int TRIM_LSB = 16;
    localparam int TRIM_W = 7;
    localparam int LOCK_BIT = 12;
    localparam int START_LSB = 8;
    localparam int START_W = 3;
    localparam int DEMAND_BIT = 7;
    localparam int STANDBY_BIT = 6;
    localparam int AMP_BIT = 5;
    localparam int EXT_OUT_BIT = 3;
    localparam int INT_OUT_BIT = 2;
    localparam int PAD_BIT = 2;
    localparam int ENABLE_BIT = 1;
    localparam int SYNC_CYCLES = 2;
    localparam int CNT_W = 8;
    localparam int IRQ_W = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic enable;
        logic crystal_pad_select;
        logic auto_amplitude_enable;
        logic slow_clock_output_enable;
    } ext_ctrl_s;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_COUNT = 3'b010,
        ST_READY = 3'b100
    } start_state_e;

    function automatic logic [CNT_W-1:0] start_count(input logic [START_W-1:0] code);
        logic [CNT_W-1:0] n;
        n = 8'h00;
        case (code)
            3'h0: n = 8'h03;
            3'h1: n = 8'h04;
            3'h2: n = 8'h06;
            3'h3: n = 8'h0A;
            3'h4: n = 8'h12;
            3'h5: n = 8'h22;
            3'h6: n = 8'h42;
            default: n = 8'h82;
        endcase
        return n;
    endfunction
endpackage

// file: rtl/slow_osc_control.sv
// Control logic for the internal and external slow oscillators.
//
// Overview of operation
// RL1 - Software loads the 7-bit trim value itself; low six bits reset to ones.
// RL2 - Once config lock is set, all writes to the internal control register are ignored.
// RL3 - Start delay code 0..7 selects 3,4,6,10,18,34,66,130 counter cycles.
// RL4 - The start-up counter runs on ultra-low-power slow oscillator ticks.
// RL5 - After the count, two more cycles pass before the ready flag sets.
// RL6 - With demand gating set, the oscillator runs only while a peripheral requests it.
// RL7 - With demand gating clear, the oscillator runs continuously while enabled.
// RL8 - With keep-alive clear, the oscillator stops in standby.
// RL9 - With keep-alive set, standby behaves as run mode, demand gated or continuous.
// RL10 - Internal bit 2 gates the internal slow clock output.
// RL11 - Internal control register at 0x18 resets to 0x003F0080.
// RL12 - External keep-alive bit keeps it running in standby, gated or continuous.
// RL13 - External bit 5 switches automatic amplitude control.
// RL14 - External bit 3 gates the external slow clock output.
// RL15 - External bit 2 selects crystal on both pads or clock on input pad.
// RL16 - External bit 1 enables the external oscillator.
// RL17 - Ready clears when the oscillator stops; counter restarts from zero on every start.
`timescale 1ns/100ps
module slow_osc_control (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire slow_osc_pkg::reg_req_s req_i,
    output logic [31:0] rdata_o,
    input wire logic standby_i,
    input wire logic int_request_i,
    input wire logic ext_request_i,
    input wire logic ulp_tick_i,
    input wire logic int_osc_tick_i,
    output logic int_osc_run_o,
    output logic [slow_osc_pkg::TRIM_W-1:0] int_trim_o,
    output logic int_clk_out_en_o,
    output logic internal_slow_osc_ready_o,
    output logic ext_osc_run_o,
    output slow_osc_pkg::ext_ctrl_s ext_ctrl_o,
    output logic irq_o
);
    import slow_osc_pkg::*;

    logic [31:0] int_ctrl;
    logic [15:0] ext_ctrl;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_status;
    logic [CNT_W-1:0] start_cnt;
    logic [1:0] sync_cnt;
    start_state_e state;
    start_state_e next_state;
    logic int_want;
    logic ext_want;
    logic ready_rise;
    logic ready_fall;
    logic rd_irq;
    logic [START_W-1:0] start_code;

    assign start_code = int_ctrl[START_LSB+START_W-1:START_LSB];
    assign rd_irq = req_i.rd && (req_i.addr == ADDR_IRQ_STATUS);

    // Internal control register with write lock.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_ctrl <= INT_CTRL_RESET; // RL11 RL1
        end else if (req_i.wr && req_i.addr == ADDR_INT_CTRL && !int_ctrl[LOCK_BIT]) begin // RL2
            int_ctrl <= req_i.wdata & INT_CTRL_WMASK; // RL1
        end
    end

    // External control register.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_ctrl <= EXT_CTRL_RESET;
        end else if (req_i.wr && req_i.addr == ADDR_EXT_CTRL && !ext_ctrl[LOCK_BIT]) begin
            ext_ctrl <= req_i.wdata[15:0] & EXT_CTRL_WMASK;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_mask <= '0;
        end else if (req_i.wr && req_i.addr == ADDR_IRQ_MASK) begin
            irq_mask <= req_i.wdata[IRQ_W-1:0];
        end
    end

    // Run decisions for both oscillators.
    always_comb begin
        int_want = int_ctrl[ENABLE_BIT]
            && (!int_ctrl[DEMAND_BIT] || int_request_i) // RL6 RL7
            && (!standby_i || int_ctrl[STANDBY_BIT]); // RL8 RL9
        ext_want = ext_ctrl[ENABLE_BIT] // RL16
            && (!ext_ctrl[DEMAND_BIT] || ext_request_i)
            && (!standby_i || ext_ctrl[STANDBY_BIT]); // RL12
    end

    // Start-up sequencer for the internal oscillator.
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (int_want) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!int_want) begin
                    next_state = ST_OFF; // RL17
                end else if (start_cnt >= start_count(start_code)
                             && sync_cnt == 2'(SYNC_CYCLES) - 2'h1 && int_osc_tick_i) begin
                    next_state = ST_READY; // RL5
                end
            end
            ST_READY: begin
                if (!int_want) begin
                    next_state = ST_OFF; // RL17
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Start-up counter clocked by ultra-low-power ticks, then sync on oscillator ticks.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_cnt <= '0;
            sync_cnt <= '0;
        end else if (state != ST_COUNT) begin
            start_cnt <= '0; // RL17
            sync_cnt <= '0;
        end else if (start_cnt < start_count(start_code)) begin
            if (ulp_tick_i) begin
                start_cnt <= start_cnt + 8'h01; // RL3 RL4
            end
        end else if (int_osc_tick_i && sync_cnt < 2'(SYNC_CYCLES) - 2'h1) begin
            sync_cnt <= sync_cnt + 2'h1; // RL5
        end
    end

    assign ready_rise = (state != ST_READY) && (next_state == ST_READY);
    assign ready_fall = (state == ST_READY) && (next_state != ST_READY);

    // Sticky event flags; a new event wins over the read clear.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (rd_irq ? '0 : irq_status) | {ready_fall, ready_rise};
        end
    end

    // Registered outputs.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_osc_run_o <= 1'b0;
            int_trim_o <= '0;
            int_clk_out_en_o <= 1'b0;
            internal_slow_osc_ready_o <= 1'b0;
            ext_osc_run_o <= 1'b0;
            ext_ctrl_o <= '0;
        end else begin
            int_osc_run_o <= (next_state != ST_OFF);
            int_trim_o <= int_ctrl[TRIM_LSB+TRIM_W-1:TRIM_LSB]; // RL1
            int_clk_out_en_o <= int_ctrl[INT_OUT_BIT] && (next_state == ST_READY); // RL10
            internal_slow_osc_ready_o <= (next_state == ST_READY); // RL5 RL17
            ext_osc_run_o <= ext_want;
            ext_ctrl_o.enable <= ext_want; // RL16
            ext_ctrl_o.crystal_pad_select <= ext_ctrl[PAD_BIT]; // RL15
            ext_ctrl_o.auto_amplitude_enable <= ext_ctrl[AMP_BIT]; // RL13
            ext_ctrl_o.slow_clock_output_enable <= ext_ctrl[EXT_OUT_BIT] && ext_want; // RL14
        end
    end

    // Read data, one cycle after the read strobe.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (req_i.rd) begin
            case (req_i.addr)
                ADDR_INT_CTRL: rdata_o <= int_ctrl;
                ADDR_EXT_CTRL: rdata_o <= {16'h0000, ext_ctrl};
                ADDR_STATUS: rdata_o <= {31'h00000000, state == ST_READY};
                ADDR_IRQ_MASK: rdata_o <= {30'h00000000, irq_mask};
                ADDR_IRQ_STATUS: rdata_o <= {30'h00000000, irq_status};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    assign irq_o = |(irq_status & irq_mask);
endmodule

// file: verif/slow_osc_props.sv
// Port checker of the slow oscillator control block.
`timescale 1ns/100ps
module slow_osc_props (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire slow_osc_pkg::reg_req_s req_i,
    input wire logic [31:0] rdata_o,
    input wire logic standby_i,
    input wire logic int_request_i,
    input wire logic ulp_tick_i,
    input wire logic int_osc_run_o,
    input wire logic int_clk_out_en_o,
    input wire logic internal_slow_osc_ready_o,
    input wire logic ext_osc_run_o,
    input wire slow_osc_pkg::ext_ctrl_s ext_ctrl_o
);
    import slow_osc_pkg::*;
    logic [31:0] sh;
    logic [7:0] cnt;
    int n;
    assign n = (1 << sh[10:8]) + 2;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of the internal control register, honouring the lock.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh <= INT_CTRL_RESET;
        end else if (req_i.wr && req_i.addr == ADDR_INT_CTRL && !sh[LOCK_BIT]) begin
            sh <= req_i.wdata & INT_CTRL_WMASK;
        end
    end
    // Counts start-up ticks of the current start.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 8'h00;
        end else if (!int_osc_run_o) begin
            cnt <= 8'h00;
        end else if (ulp_tick_i && !internal_slow_osc_ready_o) begin
            cnt <= cnt + 8'h01;
        end
    end
    AST_DISABLED: assert property ((!sh[ENABLE_BIT]) [*3] |-> !int_osc_run_o)
        else $error("oscillator runs while disabled");
    AST_CONTINUOUS: assert property ((sh[ENABLE_BIT] && !sh[DEMAND_BIT] && !standby_i) [*3]
        |-> int_osc_run_o)
        else $error("oscillator stopped in continuous mode");
    AST_DEMAND: assert property ((sh[DEMAND_BIT] && !int_request_i) [*3] |-> !int_osc_run_o)
        else $error("oscillator runs without a request");
    AST_STANDBY_OFF: assert property ((standby_i && !sh[STANDBY_BIT]) [*3] |-> !int_osc_run_o)
        else $error("oscillator runs in standby");
    AST_STANDBY_KEEP: assert property ((sh[ENABLE_BIT] && sh[STANDBY_BIT] && !sh[DEMAND_BIT]) [*3]
        |-> int_osc_run_o)
        else $error("oscillator stopped in standby");
    AST_START_COUNT: assert property ($rose(internal_slow_osc_ready_o) |-> cnt >= n - 1 && cnt <= n + 1)
        else $error("wrong start-up count");
    AST_READY_STOP: assert property (!int_osc_run_o |=> !internal_slow_osc_ready_o)
        else $error("ready without running");
    AST_OUT_EN: assert property (int_clk_out_en_o |-> internal_slow_osc_ready_o || $past(internal_slow_osc_ready_o))
        else $error("clock output before ready");
    AST_EXT_RUN: assert property (ext_osc_run_o |-> ext_ctrl_o.enable || $past(ext_ctrl_o.enable))
        else $error("external oscillator runs while disabled");
    AST_RDATA_IDLE: assert property (!$past(req_i.rd) |-> rdata_o == 32'h00000000)
        else $error("read data outside a read");
endmodule
bind slow_osc_control slow_osc_props slow_osc_props_i (.clk_sys_i, .rst_n_i, .req_i, .rdata_o,
    .standby_i, .int_request_i, .ulp_tick_i, .int_osc_run_o, .int_clk_out_en_o,
    .internal_slow_osc_ready_o, .ext_osc_run_o, .ext_ctrl_o);

// file: verif/slow_osc_source.sv
// Model of the slow oscillator sources that feed the control block.
`timescale 1ns/100ps
module slow_osc_source (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic ulp_tick_o,
    output logic osc_tick_o
);
    logic [1:0] div;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= 2'h0;
            osc_tick_o <= 1'b0;
        end else begin
            div <= div + 2'h1;
            osc_tick_o <= run_i;
        end
    end
    assign ulp_tick_o = (div == 2'h3);
endmodule

// file: verif/tb.sv
// Self-checking testbench of the slow oscillator control block.
`timescale 1ns/100ps
module tb;
    import slow_osc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    reg_req_s req_i = '0;
    logic standby_i = 1'b0;
    logic int_request_i = 1'b0;
    logic ext_request_i = 1'b0;
    logic ulp_tick_i, int_osc_tick_i, int_osc_run_o, int_clk_out_en_o;
    logic internal_slow_osc_ready_o, ext_osc_run_o, irq_o;
    logic [6:0] int_trim_o;
    logic [31:0] rdata_o, d;
    ext_ctrl_s ext_ctrl_o;
    int mismatches = 0;
    int tests_run = 0;
    initial forever #20 clk_sys_i = ~clk_sys_i;
    slow_osc_control slow_osc_control_i (.clk_sys_i, .rst_n_i, .req_i, .rdata_o, .standby_i,
        .int_request_i, .ext_request_i, .ulp_tick_i, .int_osc_tick_i, .int_osc_run_o, .int_trim_o,
        .int_clk_out_en_o, .internal_slow_osc_ready_o, .ext_osc_run_o, .ext_ctrl_o, .irq_o);
    slow_osc_source slow_osc_source_i (.clk_sys_i, .rst_n_i, .run_i(int_osc_run_o),
        .ulp_tick_o(ulp_tick_i), .osc_tick_o(int_osc_tick_i));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        req_i <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        req_i.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        req_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        req_i.rd <= 1'b0;
        #1 v = rdata_o;
    endtask
    task settle;
        repeat (5) @(posedge clk_sys_i);
        #1;
    endtask
    task conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(ADDR_INT_CTRL, d);
        chk(d, 32'h003F0080);
        rd(8'h30, d);
        chk(d, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_INT_CTRL, (c << 8) | 32'h6);
            for (int i = 0; i < 1000 && internal_slow_osc_ready_o !== 1'b1; i++) @(posedge clk_sys_i);
            rd(ADDR_STATUS, d);
            chk(d[0], 1);
            chk(int_clk_out_en_o, 1);
            chk(irq_o, 1);
            rd(ADDR_IRQ_STATUS, d);
            chk(d, c == 0 ? 1 : 3);
            chk(irq_o, 0);
            wr(ADDR_INT_CTRL, 32'h0);
            settle;
            chk(internal_slow_osc_ready_o, 0);
        end
        wr(ADDR_INT_CTRL, 32'h82);
        settle;
        chk(int_osc_run_o, 0);
        int_request_i <= 1'b1;
        settle;
        chk(int_osc_run_o, 1);
        wr(ADDR_INT_CTRL, 32'h02);
        standby_i <= 1'b1;
        settle;
        chk(int_osc_run_o, 0);
        wr(ADDR_INT_CTRL, 32'h42);
        settle;
        chk(int_osc_run_o, 1);
        ext_request_i <= 1'b1;
        wr(ADDR_EXT_CTRL, 32'hCA);
        settle;
        chk(ext_osc_run_o, 1);
        chk(ext_ctrl_o, 32'h9);
        ext_request_i <= 1'b0;
        settle;
        chk(ext_osc_run_o, 0);
        standby_i <= 1'b0;
        wr(ADDR_EXT_CTRL, 32'h2E);
        settle;
        chk(ext_ctrl_o, 32'hF);
        chk(ext_osc_run_o, 1);
        wr(ADDR_INT_CTRL, 32'h00551002);
        wr(ADDR_INT_CTRL, 32'h0);
        settle;
        chk(int_trim_o, 32'h55);
        rd(ADDR_INT_CTRL, d);
        chk(d, 32'h00551002);
        chk(int_osc_run_o, 1);
        conclude;
    end
endmodule
